/* design/cefm_params.svh */
// Register offsets, field positions, reset values and timing counts of the event flag block.
`ifndef CEFM_PARAMS_SVH
`define CEFM_PARAMS_SVH

// Register addresses as seen from the serial register engine.
`define CEFM_ADDR_FLAGS_ONE   8'h0f
`define CEFM_ADDR_FLAGS_TWO   8'h10
`define CEFM_ADDR_FAULT_FLAGS 8'h11
`define CEFM_ADDR_MASKS_ONE   8'h12

// Reset values of the flag and mask registers.
`define CEFM_FLAGS_RESET      8'h00
`define CEFM_MASKS_ONE_RESET  8'h00

// Field positions in the first flag and first mask register.
`define CEFM_BIT_CONV_DONE    7
`define CEFM_BIT_IN_CURR_REG  6
`define CEFM_BIT_IN_VOLT_REG  5
`define CEFM_BIT_DIE_HEAT_REG 4
`define CEFM_BIT_BUS_TIMEOUT  3
`define CEFM_BIT_CHARGE_PHASE 0

// Field positions in the second flag register.
`define CEFM_BIT_SUPPLY_VALID 7
`define CEFM_BIT_SOURCE_TYPE  4
`define CEFM_BIT_PACK_HEAT    2
`define CEFM_BIT_CURR_OPT     1

// Field positions in the fault flag register.
`define CEFM_BIT_OVERVOLTAGE  7
`define CEFM_BIT_DIE_SHUTDOWN 6
`define CEFM_BIT_SAFETY_TIMER 4

// Bits that exist in each register; everything else reads zero and ignores writes.
`define CEFM_FLAGS_ONE_LIVE   8'h79
`define CEFM_FLAGS_TWO_LIVE   8'h96
`define CEFM_FAULT_LIVE       8'hd0
`define CEFM_MASKS_ONE_LIVE   8'hf9

// Interrupt pulse width: time in microseconds, clock in MHz, count in cycles.
`define CEFM_SYS_CLK_MHZ      25
`define CEFM_INT_PULSE_US     100
`define CEFM_INT_PULSE_CYC    (`CEFM_INT_PULSE_US * `CEFM_SYS_CLK_MHZ)
`define CEFM_PULSE_CNT_W      12

`endif

/* design/cefm_pkg.sv */
// Types used by the interrupt pulse generator of the event flag block.
package cefm_pkg;

    // Phases of the interrupt output pulse.
    typedef enum logic [1:0]
    {
        PULSE_IDLE,
        PULSE_LOW,
        PULSE_GAP
    } cefm_pulse_state_t;

endpackage : cefm_pkg

/* design/cefm_pulse_gen.sv */
// Fixed-width active-low interrupt pulse generator.
`timescale 1ns/1ps
`default_nettype none
`include "cefm_params.svh"

module cefm_pulse_gen
(
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic eventReq,
    output var  logic intN
);

    cefm_pkg::cefm_pulse_state_t        stateQ;
    logic [`CEFM_PULSE_CNT_W-1:0]       countQ;
    logic                               pendingQ;

    // An event that lands while a pulse is in flight is remembered, so it gets a pulse of its own
    // after a two-cycle high gap instead of being swallowed by the current one.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pendingQ <= 1'b0;
        end
        else if (stateQ != cefm_pkg::PULSE_IDLE && eventReq)
        begin
            pendingQ <= 1'b1;
        end
        else if (stateQ == cefm_pkg::PULSE_IDLE)
        begin
            pendingQ <= 1'b0;
        end
    end

    // Pulse sequencing: low for the fixed count, then a gap cycle before another pulse.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stateQ <= cefm_pkg::PULSE_IDLE;
            countQ <= '0;
        end
        else
        begin
            case (stateQ)
                cefm_pkg::PULSE_IDLE:
                begin
                    if (eventReq || pendingQ)
                    begin
                        stateQ <= cefm_pkg::PULSE_LOW;
                        countQ <= `CEFM_PULSE_CNT_W'(`CEFM_INT_PULSE_CYC - 1);
                    end
                end
                cefm_pkg::PULSE_LOW:
                begin
                    if (countQ == '0)
                    begin
                        stateQ <= cefm_pkg::PULSE_GAP;
                    end
                    else
                    begin
                        countQ <= countQ - 1'b1;
                    end
                end
                default:
                begin
                    stateQ <= cefm_pkg::PULSE_IDLE;
                end
            endcase
        end
    end

    // The output is a register of its own, fed from the state, count and request, so it is glitch free.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            intN <= 1'b1;
        end
        else
        begin
            intN <= !((stateQ == cefm_pkg::PULSE_IDLE && (eventReq || pendingQ))
                      || (stateQ == cefm_pkg::PULSE_LOW && countQ != '0));
        end
    end

endmodule : cefm_pulse_gen

`default_nettype wire

/* design/charger_event_flag_mask.sv */
// Charger event flags, first mask register and interrupt request logic.
`timescale 1ns/1ps
`default_nettype none
`include "cefm_params.svh"

module charger_event_flag_mask
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output var  logic [7:0] regRdData,
    input  wire logic       regResetCmd,
    input  wire logic       input_current_regulation,
    input  wire logic       input_voltage_regulation,
    input  wire logic       die_heat_regulation,
    input  wire logic       bus_timeout_state,
    input  wire logic [2:0] charge_phase,
    input  wire logic       supply_valid,
    input  wire logic [2:0] source_type,
    input  wire logic [2:0] pack_heat_zone,
    input  wire logic [1:0] current_optimizer_phase,
    input  wire logic       input_overvoltage,
    input  wire logic       die_shutdown,
    input  wire logic       safetyTimerExpired,
    input  wire logic       convDone,
    input  wire logic       oneShotMode,
    input  wire logic [7:0] chargerMasksTwo,
    input  wire logic [7:0] faultMasks,
    output var  logic [7:0] chargerEventMasksOne,
    output var  logic       intN
);

    // Previous samples of every watched status, for edge and change detection.
    // Each one but primedQ holds the value that its source had at the last clock edge.
    logic       primedQ;
    logic       inCurrQ;
    logic       inVoltQ;
    logic       dieHeatQ;
    logic       busTimeoutQ;
    logic [2:0] chargePhaseQ;
    logic       supplyValidQ;
    logic [2:0] sourceTypeQ;
    logic [2:0] packHeatQ;
    logic [1:0] currOptQ;
    logic       overvoltageQ;
    logic       dieShutdownQ;
    logic       safetyTimerQ;

    // Flag and mask storage.
    // Flag registers only ever load live bits, so reserved positions stay zero.
    logic [7:0] chargerEventFlagsOneQ;
    logic [7:0] chargerEventFlagsTwoQ;
    logic [7:0] faultEventFlagsQ;
    logic [7:0] chargerEventMasksOneQ;

    // One-cycle event vectors laid out like the flag registers.
    // All but convDoneQ are combinational and valid only in the cycle of the edge that caused them.
    logic [7:0] setOne;
    logic [7:0] setTwo;
    logic [7:0] setFault;
    logic [7:0] clrOne;
    logic [7:0] clrTwo;
    logic [7:0] clrFault;
    logic       convDoneEvent;
    logic       convDoneQ;
    logic       intReq;

    // Masked interrupt requests, laid out like the event vectors.
    logic [7:0] reqOne;
    logic [7:0] reqTwo;
    logic [7:0] reqFault;
    logic       reqConv;

    // Status history; the first cycle after reset only loads it, so levels already present at
    // reset release do not look like fresh edges.
    // The sources come from logic on this clock, so no synchroniser sits in front of them.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            primedQ      <= 1'b0;
            inCurrQ      <= 1'b0;
            inVoltQ      <= 1'b0;
            dieHeatQ     <= 1'b0;
            busTimeoutQ  <= 1'b0;
            chargePhaseQ <= 3'h0;
            supplyValidQ <= 1'b0;
            sourceTypeQ  <= 3'h0;
            packHeatQ    <= 3'h0;
            currOptQ     <= 2'h0;
            overvoltageQ <= 1'b0;
            dieShutdownQ <= 1'b0;
            safetyTimerQ <= 1'b0;
            convDoneQ    <= 1'b0;
        end
        else
        begin
            primedQ      <= 1'b1;
            inCurrQ      <= input_current_regulation;
            inVoltQ      <= input_voltage_regulation;
            dieHeatQ     <= die_heat_regulation;
            busTimeoutQ  <= bus_timeout_state;
            chargePhaseQ <= charge_phase;
            supplyValidQ <= supply_valid;
            sourceTypeQ  <= source_type;
            packHeatQ    <= pack_heat_zone;
            currOptQ     <= current_optimizer_phase;
            overvoltageQ <= input_overvoltage;
            dieShutdownQ <= die_shutdown;
            safetyTimerQ <= safetyTimerExpired;
            convDoneQ    <= convDone;
        end
    end

    // Event detection, placed at the flag bit each event owns.
    // Multi-bit fields flag any change, so a return to an earlier value counts as well.
    // Fault sources flag only on entry; leaving a fault condition is not an event.
    // A change during the priming cycle after reset release is not seen.
    always_comb
    begin
        setOne   = 8'h00;
        setTwo   = 8'h00;
        setFault = 8'h00;
        if (primedQ)
        begin
            setOne[`CEFM_BIT_IN_CURR_REG]  = input_current_regulation && !inCurrQ;
            setOne[`CEFM_BIT_IN_VOLT_REG]  = input_voltage_regulation && !inVoltQ;
            setOne[`CEFM_BIT_DIE_HEAT_REG] = die_heat_regulation && !dieHeatQ;
            setOne[`CEFM_BIT_BUS_TIMEOUT]  = bus_timeout_state && !busTimeoutQ;
            setOne[`CEFM_BIT_CHARGE_PHASE] = charge_phase != chargePhaseQ;
            setTwo[`CEFM_BIT_SUPPLY_VALID] = supply_valid != supplyValidQ;
            setTwo[`CEFM_BIT_SOURCE_TYPE]  = source_type != sourceTypeQ;
            setTwo[`CEFM_BIT_PACK_HEAT]    = pack_heat_zone != packHeatQ;
            setTwo[`CEFM_BIT_CURR_OPT]     = current_optimizer_phase != currOptQ;
            setFault[`CEFM_BIT_OVERVOLTAGE]  = input_overvoltage && !overvoltageQ;
            setFault[`CEFM_BIT_DIE_SHUTDOWN] = die_shutdown && !dieShutdownQ;
            setFault[`CEFM_BIT_SAFETY_TIMER] = safetyTimerExpired && !safetyTimerQ;
        end
    end

    // Conversion-done has no flag of its own and only counts in one-shot mode.
    // Its mask bit sits in the first mask register, above the flag-one masks.
    assign convDoneEvent = primedQ && convDone && !convDoneQ && oneShotMode;

    // A read of a flag register clears what it returned; a register reset clears everything.
    // Clearing exactly the returned value keeps an event that lands during the read.
    always_comb
    begin
        clrOne   = 8'h00;
        clrTwo   = 8'h00;
        clrFault = 8'h00;
        if (regResetCmd)
        begin
            clrOne   = 8'hff;
            clrTwo   = 8'hff;
            clrFault = 8'hff;
        end
        else if (regRdEn && regAddr == `CEFM_ADDR_FLAGS_ONE)
        begin
            clrOne = chargerEventFlagsOneQ;
        end
        else if (regRdEn && regAddr == `CEFM_ADDR_FLAGS_TWO)
        begin
            clrTwo = chargerEventFlagsTwoQ;
        end
        else if (regRdEn && regAddr == `CEFM_ADDR_FAULT_FLAGS)
        begin
            clrFault = faultEventFlagsQ;
        end
    end

    // Sticky flags: a new event in the clearing cycle wins, so nothing is lost between a read
    // and the next. Only live bits can ever be set; reserved bits stay zero.
    // A register reset yields to a fresh event as well: a strict clear was traded for never
    // losing an event that the host has not yet seen.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            chargerEventFlagsOneQ <= `CEFM_FLAGS_RESET;
            chargerEventFlagsTwoQ <= `CEFM_FLAGS_RESET;
            faultEventFlagsQ      <= `CEFM_FLAGS_RESET;
        end
        else
        begin
            chargerEventFlagsOneQ <= ((chargerEventFlagsOneQ & ~clrOne) | setOne)
                                     & `CEFM_FLAGS_ONE_LIVE;
            chargerEventFlagsTwoQ <= ((chargerEventFlagsTwoQ & ~clrTwo) | setTwo)
                                     & `CEFM_FLAGS_TWO_LIVE;
            faultEventFlagsQ      <= ((faultEventFlagsQ & ~clrFault) | setFault)
                                     & `CEFM_FAULT_LIVE;
        end
    end

    // First mask register: register reset beats a write in the same cycle. Bus watchdog expiry
    // has no path in here, so masks and flags survive it.
    // Reserved positions are dropped at the write, so they can never read back as ones.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            chargerEventMasksOneQ <= `CEFM_MASKS_ONE_RESET;
        end
        else if (regResetCmd)
        begin
            chargerEventMasksOneQ <= `CEFM_MASKS_ONE_RESET;
        end
        else if (regWrEn && regAddr == `CEFM_ADDR_MASKS_ONE)
        begin
            chargerEventMasksOneQ <= regWrData & `CEFM_MASKS_ONE_LIVE;
        end
    end

    // The mask register is exported for the rest of the register map.
    assign chargerEventMasksOne = chargerEventMasksOneQ;

    // Read data is captured on the read strobe; flag registers are read-only and unmapped
    // addresses return zero.
    // The data holds between reads, so a slow register engine may pick it up late.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            regRdData <= 8'h00;
        end
        else if (regRdEn)
        begin
            if (regAddr == `CEFM_ADDR_FLAGS_ONE)
            begin
                regRdData <= chargerEventFlagsOneQ;
            end
            else if (regAddr == `CEFM_ADDR_FLAGS_TWO)
            begin
                regRdData <= chargerEventFlagsTwoQ;
            end
            else if (regAddr == `CEFM_ADDR_FAULT_FLAGS)
            begin
                regRdData <= faultEventFlagsQ;
            end
            else if (regAddr == `CEFM_ADDR_MASKS_ONE)
            begin
                regRdData <= chargerEventMasksOneQ;
            end
            else
            begin
                regRdData <= 8'h00;
            end
        end
    end

    // Masked requests, one vector per flag register. Masks gate only the pulse; the flag is
    // set regardless, so a polling host still sees every event except conversion-done, which has no flag.
    assign reqOne   = setOne & ~chargerEventMasksOneQ;
    assign reqTwo   = setTwo & ~chargerMasksTwo;
    assign reqFault = setFault & ~faultMasks;
    assign reqConv  = convDoneEvent && !chargerEventMasksOneQ[`CEFM_BIT_CONV_DONE];

    // Events that land together share one request; the pulse generator spaces out later ones.
    assign intReq = (|reqOne) || (|reqTwo) || (|reqFault) || reqConv;

    // Pulse shaping of the interrupt output.
    // One pulse per request from idle; any requests during a pulse earn a single one more after a short gap.
    cefm_pulse_gen u_pulse_gen
    (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .eventReq (intReq),
        .intN     (intN)
    );

endmodule : charger_event_flag_mask

`default_nettype wire

/* verification/cefm_assertions.sv */
// Concurrent checks on the ports of the charger event flag block.
`timescale 1ns/1ps
`default_nettype none
`include "cefm_params.svh"

module cefm_checker
(
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       regResetCmd,
    input wire logic [7:0] chargerEventMasksOne,
    input wire logic       intN
);
    logic [11:0] lowCnt_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Counts the low phase so that its width is judged when it ends.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            lowCnt_q <= 12'h000;
        else if (!intN)
            lowCnt_q <= lowCnt_q + 12'h001;
        else
            lowCnt_q <= 12'h000;
    end

    // A plain read of the mask register, with no write racing it.
    sequence rdMask;
        regRdEn && !regWrEn && !regResetCmd && regAddr == 8'h12;
    endsequence

    a_rd_mask: assert property (rdMask |=> regRdData == $past(chargerEventMasksOne))
        else $error("mask read returned a wrong value");
    a_rd_hold: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data moved without a read");
    a_rd_unmapped: assert property
        (regRdEn && (regAddr < 8'h0f || regAddr > 8'h12) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_mask_resvd: assert property ((chargerEventMasksOne & 8'h06) == 8'h00)
        else $error("reserved mask bits set");
    a_mask_write: assert property
        (regWrEn && !regResetCmd && regAddr == 8'h12
            |=> chargerEventMasksOne == ($past(regWrData) & 8'hf9))
        else $error("mask write not taken");
    a_reset_cmd: assert property (regResetCmd |=> chargerEventMasksOne == 8'h00)
        else $error("register reset left masks set");
    a_pulse_width: assert property ($rose(intN) |-> lowCnt_q == `CEFM_INT_PULSE_CYC)
        else $error("interrupt pulse width wrong");
    a_pulse_max: assert property (lowCnt_q <= `CEFM_INT_PULSE_CYC)
        else $error("interrupt pulse too long");
    a_pulse_gap: assert property ($rose(intN) |=> intN)
        else $error("no high gap after pulse");
endmodule : cefm_checker
`default_nettype wire

/* verification/cefm_host_model.sv */
// Host-side model that reaches the block's registers through its strobes.
`timescale 1ns/1ps
`default_nettype none

module cefm_host_model
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] regRdData,
    output var  logic [7:0] regAddr,
    output var  logic       regWrEn,
    output var  logic [7:0] regWrData,
    output var  logic       regRdEn,
    output var  logic       regResetCmd
);
    // Idle bus at time zero.
    initial
    begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
        regResetCmd = 1'b0;
    end

    // Write strobe for one cycle; data is scrambled after so stale values never pass.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge sys_clk);
        regWrEn = 1'b0;
        regWrData = ~d;
    endtask : wr

    // Read data is taken one cycle after the strobe edge; the host finds causes this way.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge sys_clk);
        regRdEn = 1'b0;
        d = regRdData;
    endtask : rd

    // One-cycle register reset command.
    task automatic rst_cmd();
        @(negedge sys_clk);
        regResetCmd = 1'b1;
        @(negedge sys_clk);
        regResetCmd = 1'b0;
    endtask : rst_cmd
endmodule : cefm_host_model
`default_nettype wire

/* verification/tb_charger_event_flag_mask.sv */
// Self-checking bench for the charger event flag and mask block.
`timescale 1ns/1ps
`default_nettype none

module tb_charger_event_flag_mask;
    logic        sys_clk;
    logic        resetn;
    logic [20:0] st;
    logic [7:0]  masksTwo;
    logic [7:0]  faultMask;
    logic [7:0]  regAddr;
    logic        regWrEn;
    logic [7:0]  regWrData;
    logic        regRdEn;
    logic [7:0]  regRdData;
    logic        regResetCmd;
    logic [7:0]  mOne;
    logic        intN;
    logic [7:0]  got;
    logic [7:0]  evAddr;
    int          n_errors;
    int          num_checks;
    int          evBit [12] = '{0, 1, 2, 3, 4, 7, 8, 11, 14, 16, 17, 18};
    logic [7:0]  evExp [12] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h01, 8'h80,
                                8'h10, 8'h04, 8'h02, 8'h80, 8'h40, 8'h10};
    int          mBit [5] = '{6, 5, 4, 3, 0};

    cefm_host_model host (.sys_clk(sys_clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regResetCmd(regResetCmd));

    charger_event_flag_mask DUT (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .regResetCmd(regResetCmd),
        .input_current_regulation(st[0]), .input_voltage_regulation(st[1]),
        .die_heat_regulation(st[2]), .bus_timeout_state(st[3]), .charge_phase(st[6:4]),
        .supply_valid(st[7]), .source_type(st[10:8]), .pack_heat_zone(st[13:11]),
        .current_optimizer_phase(st[15:14]), .input_overvoltage(st[16]),
        .die_shutdown(st[17]), .safetyTimerExpired(st[18]), .convDone(st[19]),
        .oneShotMode(st[20]), .chargerMasksTwo(masksTwo), .faultMasks(faultMask),
        .chargerEventMasksOne(mOne), .intN(intN));

    // Free-running 25 MHz clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, got);
        chk("regRdData", e, got);
    endtask : rdc

    // Flips one status input and looks for a low pulse in the following cycles.
    task automatic pulse(input int b, input logic want);
        logic seen;
        int   n;
        seen = 1'b0;
        n = 0;
        @(negedge sys_clk);
        st[b] = ~st[b];
        repeat (6) @(negedge sys_clk) if (intN === 1'b0) seen = 1'b1;
        chk("intN pulse", {7'h00, want}, {7'h00, seen});
        while (intN !== 1'b1 && n < 3000)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk("intN idle", 8'h01, {7'h00, intN});
        repeat (3) @(negedge sys_clk);
    endtask : pulse

    // A hang is cut short well past the expected run of about a millisecond.
    initial
    begin
        #2000000;
        n_errors++;
        close_out();
    end

    initial
    begin
        resetn = 1'b0;
        st = '0;
        masksTwo = 8'hff;
        faultMask = 8'hff;
        n_errors = 0;
        num_checks = 0;
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (3) @(negedge sys_clk);
        for (int a = 8'h0f; a <= 8'h13; a++) rdc(8'(a), 8'h00);
        host.wr(8'h12, 8'hff);
        rdc(8'h12, 8'hf9);
        chk("chargerEventMasksOne", 8'hf9, mOne);
        host.wr(8'h0f, 8'hff);
        rdc(8'h0f, 8'h00);
        // Every source with all interrupts blocked: set, read-clear, then the opposite edge.
        for (int i = 0; i < 12; i++)
        begin
            evAddr = i < 5 ? 8'h0f : (i < 9 ? 8'h10 : 8'h11);
            st[evBit[i]] = 1'b1;
            repeat (3) @(negedge sys_clk);
            rdc(evAddr, evExp[i]);
            rdc(evAddr, 8'h00);
            st[evBit[i]] = 1'b0;
            repeat (3) @(negedge sys_clk);
            rdc(evAddr, (i >= 4 && i <= 8) ? evExp[i] : 8'h00);
            chk("intN", 8'h01, {7'h00, intN});
        end
        // Bus timeout expiry came and went above; the masks must have survived it.
        chk("chargerEventMasksOne", 8'hf9, mOne);
        st[0] = 1'b1;
        st[7] = 1'b1;
        st[16] = 1'b1;
        repeat (3) @(negedge sys_clk);
        host.rst_cmd();
        rdc(8'h0f, 8'h00);
        rdc(8'h10, 8'h00);
        rdc(8'h11, 8'h00);
        rdc(8'h12, 8'h00);
        chk("chargerEventMasksOne", 8'h00, mOne);
        st[0] = 1'b0;
        st[16] = 1'b0;
        // Each flag-one mask bit: blocked rise, idle fall, then an unblocked rise.
        for (int k = 0; k < 5; k++)
        begin
            host.wr(8'h12, 8'hf9);
            pulse(k, 1'b0);
            pulse(k, 1'b0);
            host.wr(8'h12, 8'hf9 & ~(8'h01 << mBit[k]));
            pulse(k, 1'b1);
        end
        masksTwo = 8'h7f;
        pulse(7, 1'b1);
        masksTwo = 8'hff;
        pulse(7, 1'b0);
        host.wr(8'h12, 8'h79);
        st[20] = 1'b1;
        pulse(19, 1'b1);
        pulse(19, 1'b0);
        host.wr(8'h12, 8'hff);
        pulse(19, 1'b0);
        faultMask = 8'h7f;
        pulse(16, 1'b1);
        close_out();
    end
endmodule : tb_charger_event_flag_mask

bind charger_event_flag_mask cefm_checker u_chk (.sys_clk(sys_clk), .resetn(resetn),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .regResetCmd(regResetCmd),
    .chargerEventMasksOne(chargerEventMasksOne), .intN(intN));
`default_nettype wire
